// >>> src/status_summary_pkg.sv
// Package for the transceiver status summary register block.
// Assumes a management frame engine outside that turns serial
// accesses into one-cycle register read and write strobes.
package status_summary_pkg;

	// Management register address width and data width
	localparam int unsigned ADDR_W = 5;
	localparam int unsigned DATA_W = 16;

	// Register offsets seen on the management port
	localparam logic [4:0] BASIC_STATUS_ADDR    = 5'h01;
	localparam logic [4:0] NEG_EXPANSION_ADDR   = 5'h06;
	localparam logic [4:0] STATUS_SUMMARY_ADDR  = 5'h10;
	localparam logic [4:0] INTERRUPT_STATUS_ADDR = 5'h12;
	localparam logic [4:0] FALSE_CARRIER_ADDR   = 5'h14;
	localparam logic [4:0] RX_ERROR_COUNT_ADDR  = 5'h15;
	localparam logic [4:0] TEN_BASE_STATUS_ADDR = 5'h1a;

	// Field positions inside the status summary word
	localparam int unsigned RESERVED_BIT      = 15;
	localparam int unsigned CROSSOVER_BIT     = 14;
	localparam int unsigned RX_ERROR_BIT      = 13;
	localparam int unsigned POLARITY_BIT      = 12;
	localparam int unsigned FALSE_CARRIER_BIT = 11;
	localparam int unsigned SIGNAL_DETECT_BIT = 10;
	localparam int unsigned DESCR_LOCK_BIT    = 9;
	localparam int unsigned PAGE_RX_BIT       = 8;
	localparam int unsigned IRQ_PENDING_BIT   = 7;
	localparam int unsigned REMOTE_FAULT_BIT  = 6;
	localparam int unsigned JABBER_BIT        = 5;
	localparam int unsigned AN_COMPLETE_BIT   = 4;
	localparam int unsigned LOOPBACK_BIT      = 3;
	localparam int unsigned DUPLEX_BIT        = 2;
	localparam int unsigned SPEED10_BIT       = 1;
	localparam int unsigned LINK_BIT          = 0;

	// Reset value of the whole summary word
	localparam logic [15:0] STATUS_SUMMARY_RESET = 16'h0000;

	// Number of interrupt event sources feeding the pending flag
	localparam int unsigned IRQ_EVENTS = 8;

endpackage

// >>> src/status_summary_reg.sv
// Status summary register of a 10/100 Ethernet transceiver.
// Assumes synchronous status inputs and one-cycle management strobes
// from a frame engine that multiplexes read data of all registers.
// Writes are never stored; every bit but 15 comes from status flops.
// How it works
// - Bit 15 reads zero, writes dropped
// - Bit 14 shows pair swap state
// - Swap bit follows force, enable, live algorithm
// - Bit 13 latches rx error, counter read clears
// - Bit 12 polarity, cleared by 10M status read
// - Bit 11 latches false carrier, 14h read clears
// - Bit 10 qualified signal detect, latches low
// - Bit 9 descrambler lock, latches low
// - Bit 8 page received, cleared by 06h read
// - Bit 7 interrupt pending, cleared by 12h read
// - Bit 6 remote fault, cleared by 01h read
// - Bit 5 copies jabber, summary read keeps it
// - Bit 4 shows negotiation complete
// - Bit 3 shows loopback enabled
// - Bit 2 duplex, valid with link conditions
// - Bit 0 copies link, summary read keeps it
// - Pending needs event enable and global enable, or the test input
`timescale 1ns/1ps

module status_summary_reg
	import status_summary_pkg::*;
#(
	parameter int unsigned N_EVENTS = status_summary_pkg::IRQ_EVENTS
) (
	// Clock and reset
	input  wire logic                                 ref_clk_in,
	input  wire logic                                 rst_b_in,
	// Management register access
	input  wire logic [status_summary_pkg::ADDR_W-1:0] mgmt_addr_in,
	input  wire logic                                 mgmt_rd_in,
	input  wire logic                                 mgmt_wr_in,
	input  wire logic [status_summary_pkg::DATA_W-1:0] mgmt_wdata_in,
	output logic      [status_summary_pkg::DATA_W-1:0] mgmt_rdata_out,
	output logic                                      mgmt_rvalid_out,
	// Crossover control and algorithm state
	input  wire logic                                 auto_crossover_enable_in,
	input  wire logic                                 crossover_force_in,
	input  wire logic                                 crossover_algo_swap_in,
	// Error and carrier events, one-cycle pulses
	input  wire logic                                 rx_error_event_in,
	input  wire logic                                 false_carrier_event_in,
	input  wire logic                                 polarity_inverted_in,
	input  wire logic                                 page_received_in,
	input  wire logic                                 remote_fault_in,
	// Receive path levels
	input  wire logic                                 signal_detect_raw_in,
	input  wire logic                                 descrambler_lock_in,
	input  wire logic                                 sd_lock_qualify_in,
	// Interrupt sources and enables
	input  wire logic [N_EVENTS-1:0]                  irq_event_in,
	input  wire logic [N_EVENTS-1:0]                  irq_event_enable_in,
	input  wire logic                                 irq_global_enable_in,
	input  wire logic                                 irq_test_in,
	// Link state levels
	input  wire logic                                 jabber_in,
	input  wire logic                                 an_enable_in,
	input  wire logic                                 an_complete_in,
	input  wire logic                                 loopback_in,
	input  wire logic                                 full_duplex_in,
	input  wire logic                                 speed10_in,
	input  wire logic                                 link_valid_in,
	// Qualified signal detect towards the link monitor
	output logic                                      sd_qualified_out
);
	import status_summary_pkg::*;

	typedef struct packed {
		logic        crossover;
		logic        rx_error;
		logic        polarity;
		logic        false_carrier;
		logic        sd_low_seen;
		logic        lock_low_seen;
		logic        page_rx;
		logic        irq_pending;
		logic        remote_fault;
		logic        jabber;
		logic        an_complete;
		logic        loopback;
		logic        duplex;
		logic        speed10;
		logic        link;
		logic        sd_qual;
		logic        lock;
		logic [15:0] rdata;
		logic        rvalid;
	} state_t;

	// Fields mapped to the word start from the package reset word, so reads give zero
	localparam state_t STATE_RESET = '{
		crossover:     STATUS_SUMMARY_RESET[CROSSOVER_BIT],
		rx_error:      STATUS_SUMMARY_RESET[RX_ERROR_BIT],
		polarity:      STATUS_SUMMARY_RESET[POLARITY_BIT],
		false_carrier: STATUS_SUMMARY_RESET[FALSE_CARRIER_BIT],
		sd_low_seen:   1'b0,
		lock_low_seen: 1'b0,
		page_rx:       STATUS_SUMMARY_RESET[PAGE_RX_BIT],
		irq_pending:   STATUS_SUMMARY_RESET[IRQ_PENDING_BIT],
		remote_fault:  STATUS_SUMMARY_RESET[REMOTE_FAULT_BIT],
		jabber:        STATUS_SUMMARY_RESET[JABBER_BIT],
		an_complete:   STATUS_SUMMARY_RESET[AN_COMPLETE_BIT],
		loopback:      STATUS_SUMMARY_RESET[LOOPBACK_BIT],
		duplex:        STATUS_SUMMARY_RESET[DUPLEX_BIT],
		speed10:       STATUS_SUMMARY_RESET[SPEED10_BIT],
		link:          STATUS_SUMMARY_RESET[LINK_BIT],
		sd_qual:       STATUS_SUMMARY_RESET[SIGNAL_DETECT_BIT],
		lock:          STATUS_SUMMARY_RESET[DESCR_LOCK_BIT],
		rdata:         STATUS_SUMMARY_RESET,
		rvalid:        1'b0
	};

	state_t state_ff;
	state_t nxt_state;

	// Sticky flag: a set in the clearing cycle wins so no event is lost
	function automatic logic sticky(
		input logic q,
		input logic set,
		input logic clr
	);
		sticky = set | (q & ~clr);
	endfunction

	// Latch-low memory: remembers a low level until this word is read,
	// then restarts from the present level
	function automatic logic low_mem(
		input logic q,
		input logic level,
		input logic rd
	);
		low_mem = rd ? ~level : (q | ~level);
	endfunction

	// Read strobe decoded for one management address
	function automatic logic rd_hit(
		input logic [4:0] addr,
		input logic       rd,
		input logic [4:0] target
	);
		rd_hit = rd & (addr == target);
	endfunction

	// Word presented on a read, built only from state flops
	function automatic logic [15:0] pack_summary(
		input state_t s
	);
		logic [15:0] w;
		w                    = STATUS_SUMMARY_RESET;
		w[RESERVED_BIT]      = 1'b0;
		w[CROSSOVER_BIT]     = s.crossover;
		w[RX_ERROR_BIT]      = s.rx_error;
		w[POLARITY_BIT]      = s.polarity;
		w[FALSE_CARRIER_BIT] = s.false_carrier;
		// A low seen since the last summary read keeps these at zero
		w[SIGNAL_DETECT_BIT] = s.sd_qual & ~s.sd_low_seen;
		w[DESCR_LOCK_BIT]    = s.lock & ~s.lock_low_seen;
		w[PAGE_RX_BIT]       = s.page_rx;
		w[IRQ_PENDING_BIT]   = s.irq_pending;
		w[REMOTE_FAULT_BIT]  = s.remote_fault;
		w[JABBER_BIT]        = s.jabber;
		w[AN_COMPLETE_BIT]   = s.an_complete;
		w[LOOPBACK_BIT]      = s.loopback;
		w[DUPLEX_BIT]        = s.duplex;
		w[SPEED10_BIT]       = s.speed10;
		w[LINK_BIT]          = s.link;
		pack_summary = w;
	endfunction

	// Read strobes, one per register whose read clears a flag
	logic        rd_summary;
	logic        rd_basic;
	logic        rd_expansion;
	logic        rd_irq_status;
	logic        rd_false_carrier;
	logic        rd_rx_error;
	logic        rd_ten_base;
	logic        sd_now;
	logic        link_ok;
	logic        irq_masked;
	logic        irq_fire;
	logic        duplex_now;
	logic        speed10_now;
	logic [15:0] summary_word;

	// Reads of other registers double as clear events for mirrored flags
	always_comb begin
		rd_summary = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			STATUS_SUMMARY_ADDR
		);
		rd_basic = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			BASIC_STATUS_ADDR
		);
		rd_expansion = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			NEG_EXPANSION_ADDR
		);
		rd_irq_status = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			INTERRUPT_STATUS_ADDR
		);
		rd_false_carrier = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			FALSE_CARRIER_ADDR
		);
		rd_rx_error = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			RX_ERROR_COUNT_ADDR
		);
		rd_ten_base = rd_hit(
			mgmt_addr_in,
			mgmt_rd_in,
			TEN_BASE_STATUS_ADDR
		);
	end

	always_comb begin
		// Lock only qualifies detect when the pcs option asks for it
		if (sd_lock_qualify_in) begin
			sd_now = signal_detect_raw_in &
				descrambler_lock_in;
		end else begin
			sd_now = signal_detect_raw_in;
		end

		// Duplex and speed only mean something on a settled link
		link_ok     = link_valid_in & (~an_enable_in | an_complete_in);
		duplex_now  = link_ok & full_duplex_in;
		speed10_now = link_ok & speed10_in;

		// Pending needs both the source enable and the global enable, or the test input
		irq_masked = |(irq_event_in & irq_event_enable_in);
		irq_fire   = (irq_masked & irq_global_enable_in) |
			irq_test_in;
	end

	always_comb begin
		summary_word = pack_summary(state_ff);
	end

	// Next value of every flop, in the bit order of the word
	always_comb begin
		nxt_state = state_ff;

		// Forcing beats the algorithm; disabled and unforced is normal
		if (crossover_force_in) begin
			nxt_state.crossover = 1'b1;
		end else if (auto_crossover_enable_in) begin
			nxt_state.crossover = crossover_algo_swap_in;
		end else begin
			nxt_state.crossover = 1'b0;
		end

		nxt_state.rx_error = sticky(
			state_ff.rx_error,
			rx_error_event_in,
			rd_rx_error
		);
		nxt_state.polarity = sticky(
			state_ff.polarity,
			polarity_inverted_in,
			rd_ten_base
		);
		nxt_state.false_carrier = sticky(
			state_ff.false_carrier,
			false_carrier_event_in,
			rd_false_carrier
		);

		nxt_state.sd_qual = sd_now;
		nxt_state.sd_low_seen = low_mem(
			state_ff.sd_low_seen,
			sd_now,
			rd_summary
		);
		nxt_state.lock = descrambler_lock_in;
		nxt_state.lock_low_seen = low_mem(
			state_ff.lock_low_seen,
			descrambler_lock_in,
			rd_summary
		);

		nxt_state.page_rx = sticky(
			state_ff.page_rx,
			page_received_in,
			rd_expansion
		);
		nxt_state.irq_pending = sticky(
			state_ff.irq_pending,
			irq_fire,
			rd_irq_status
		);
		nxt_state.remote_fault = sticky(
			state_ff.remote_fault,
			remote_fault_in,
			rd_basic
		);

		// Plain mirrors; a summary read never touches them
		nxt_state.jabber      = jabber_in;
		nxt_state.an_complete = an_complete_in;
		nxt_state.loopback    = loopback_in;
		nxt_state.duplex      = duplex_now;
		nxt_state.speed10     = speed10_now;
		nxt_state.link        = link_valid_in;

		// Writes are accepted by the frame engine and dropped here
		// Answer stands one cycle, then the bus returns to zero
		nxt_state.rvalid = rd_summary;
		if (rd_summary) begin
			nxt_state.rdata = summary_word;
		end else begin
			nxt_state.rdata = STATUS_SUMMARY_RESET;
		end
	end

	// One register stage; every output is a field of it
	always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_ff <= STATE_RESET;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign mgmt_rdata_out   = state_ff.rdata;
	assign mgmt_rvalid_out  = state_ff.rvalid;
	assign sd_qualified_out = state_ff.sd_qual;

endmodule

// >>> verif/status_summary_properties.sv
// Checker for the status summary register block, bound to its top.
// Assumes one clock, active-low async reset, one-cycle read strobes.
`timescale 1ns/1ps

module status_summary_props
	import status_summary_pkg::*;
(
	input wire logic        ref_clk_in, rst_b_in, mgmt_rd_in, mgmt_rvalid_out,
	input wire logic [4:0]  mgmt_addr_in,
	input wire logic [15:0] mgmt_rdata_out,
	input wire logic        crossover_force_in, link_valid_in, loopback_in,
	input wire logic        signal_detect_raw_in, descrambler_lock_in,
	input wire logic        sd_lock_qualify_in, sd_qualified_out
);
	logic sr;
	assign sr = mgmt_rd_in && mgmt_addr_in == STATUS_SUMMARY_ADDR;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!rst_b_in);
	rsv_zero_a: assert property (!mgmt_rdata_out[15])
		else $error("reserved bit read high");
	idle_zero_a: assert property (!mgmt_rvalid_out |-> !mgmt_rdata_out)
		else $error("read data without answer");
	read_answer_a: assert property (sr |=> mgmt_rvalid_out)
		else $error("summary read not answered");
	no_answer_a: assert property (!sr |=> !mgmt_rvalid_out)
		else $error("answer without summary read");
	swap_force_a: assert property (sr && crossover_force_in
		&& $past(crossover_force_in) && $past(rst_b_in) |=> mgmt_rdata_out[14])
		else $error("forced swap not shown");
	link_copy_a: assert property (sr && $stable(link_valid_in)
		&& $past(rst_b_in) |=> mgmt_rdata_out[0] == $past(link_valid_in, 2))
		else $error("link bit wrong");
	loop_copy_a: assert property (sr && $stable(loopback_in)
		&& $past(rst_b_in) |=> mgmt_rdata_out[3] == $past(loopback_in, 2))
		else $error("loopback bit wrong");
	mode_valid_a: assert property (sr && !link_valid_in
		&& !$past(link_valid_in) |=> mgmt_rdata_out[2:1] == 2'h0)
		else $error("duplex or speed shown without link");
	sd_qual_a: assert property ($past(rst_b_in) |-> sd_qualified_out ==
		($past(signal_detect_raw_in) && ($past(descrambler_lock_in)
		|| !$past(sd_lock_qualify_in)))) else $error("qualified detect wrong");
endmodule

bind status_summary_reg status_summary_props status_summary_props_i (
	.ref_clk_in, .rst_b_in, .mgmt_rd_in, .mgmt_rvalid_out, .mgmt_addr_in,
	.mgmt_rdata_out, .crossover_force_in, .link_valid_in, .loopback_in,
	.signal_detect_raw_in, .descrambler_lock_in, .sd_lock_qualify_in,
	.sd_qualified_out);

// >>> verif/mgmt_host_model.sv
// Management host model: one-cycle read or write strobes.
// Assumes the answer shows one edge after the strobe is taken.
`timescale 1ns/1ps

module mgmt_host_model (
	input  wire logic        ref_clk_in,
	input  wire logic [15:0] mgmt_rdata_in,
	input  wire logic        mgmt_rvalid_in,
	output logic      [4:0]  mgmt_addr_out,
	output logic             mgmt_rd_out,
	output logic             mgmt_wr_out,
	output logic      [15:0] mgmt_wdata_out
);
	initial begin
		{mgmt_addr_out, mgmt_rd_out, mgmt_wr_out, mgmt_wdata_out} = '0;
	end
	// Idle address and data lines show the inverse and strobes drop to zero, so stale values never look valid
	task automatic acc(input logic w, input logic [4:0] a,
		input logic [15:0] d, output logic [15:0] q, output logic v);
		@(negedge ref_clk_in);
		mgmt_addr_out = a;
		mgmt_wdata_out = d;
		mgmt_rd_out = !w;
		mgmt_wr_out = w;
		@(negedge ref_clk_in);
		q = mgmt_rdata_in;
		v = mgmt_rvalid_in;
		{mgmt_rd_out, mgmt_wr_out} = 2'h0;
		mgmt_addr_out = ~a;
		mgmt_wdata_out = ~d;
	endtask
endmodule

// >>> verif/phy_status_summary_register_tb_top.sv
// Testbench for the status summary register with a reference model.
// Assumes the host model drives all management strobes.
`timescale 1ns/1ps

module phy_status_summary_register_tb_top;
	import status_summary_pkg::*;
	logic ref_clk_in, rst_b_in, rd, wr, rv, sdq, ok, q;
	logic xen, xf, xalg, rxe, fce, pol, pg, rf, sdr, lk, ql, tst, glb;
	logic jb, ane, anc, lb, fd, s10, lv;
	logic [4:0]  addr;
	logic [7:0]  iev, ien;
	logic [15:0] wd, rdata, got;
	logic [4:0]  clr [6] = '{RX_ERROR_COUNT_ADDR, FALSE_CARRIER_ADDR,
		TEN_BASE_STATUS_ADDR, NEG_EXPANSION_ADDR, INTERRUPT_STATUS_ADDR,
		BASIC_STATUS_ADDR};
	int flg [6];
	int num_errors, checks_done, i, sdlow, lklow;

	status_summary_reg status_summary_reg_i (.ref_clk_in, .rst_b_in,
		.mgmt_addr_in(addr), .mgmt_rd_in(rd), .mgmt_wr_in(wr),
		.mgmt_wdata_in(wd), .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rv),
		.auto_crossover_enable_in(xen), .crossover_force_in(xf),
		.crossover_algo_swap_in(xalg), .rx_error_event_in(rxe),
		.false_carrier_event_in(fce), .polarity_inverted_in(pol),
		.page_received_in(pg), .remote_fault_in(rf),
		.signal_detect_raw_in(sdr), .descrambler_lock_in(lk),
		.sd_lock_qualify_in(ql), .irq_event_in(iev),
		.irq_event_enable_in(ien), .irq_global_enable_in(glb),
		.irq_test_in(tst), .jabber_in(jb), .an_enable_in(ane),
		.an_complete_in(anc), .loopback_in(lb), .full_duplex_in(fd),
		.speed10_in(s10), .link_valid_in(lv), .sd_qualified_out(sdq));
	mgmt_host_model mgmt_host_model_i (.ref_clk_in, .mgmt_rdata_in(rdata),
		.mgmt_rvalid_in(rv), .mgmt_addr_out(addr), .mgmt_rd_out(rd),
		.mgmt_wr_out(wr), .mgmt_wdata_out(wd));

	initial begin
		ref_clk_in = 0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end

	task automatic chk(input logic [15:0] a, input logic [15:0] e);
		checks_done++;
		if (a !== e) begin
			num_errors++;
			$display("ERROR t=%0t got %h exp %h", $time, a, e);
		end
	endtask

	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	// Expected word; latch-low memories are kept in sdlow and lklow
	function automatic logic [15:0] model();
		logic v;
		v = lv && (!ane || anc);
		return {1'b0, xf | (xen & xalg), flg[0][0], flg[2][0], flg[1][0],
			q & !sdlow[0], lk & !lklow[0], flg[3][0], flg[4][0], flg[5][0],
			jb, anc, lb, v & fd, v & s10, lv};
	endfunction

	initial begin
		{xen, xf, xalg, rxe, fce, pol, pg, rf, sdr, lk, ql, tst, glb} = '0;
		{jb, ane, anc, lb, fd, s10, lv, iev, ien, q} = '0;
		rst_b_in = 0;
		flg = '{default: 0};
		{sdlow, lklow} = {32'd1, 32'd1};
		i = $urandom(3);
		repeat (12) @(posedge ref_clk_in);
		@(negedge ref_clk_in) rst_b_in = 1;
		mgmt_host_model_i.acc(0, STATUS_SUMMARY_ADDR, 16'h0, got, ok);
		chk(got, 16'h0000);
		for (i = 0; i < 300; i++) begin
			@(negedge ref_clk_in);
			{xen, xf, xalg, sdr, lk, ql, jb, ane, anc, lb, fd, s10, lv} =
				13'($urandom);
			ien = 8'($urandom);
			glb = 1'($urandom);
			q = sdr && (lk || !ql);
			sdlow = sdlow | !q;
			lklow = lklow | !lk;
			repeat (3) @(negedge ref_clk_in);
			for (int k = 0; k < 6; k++) begin
				if ($urandom % 3 == 0) begin
					mgmt_host_model_i.acc(0, clr[k], 16'h0, got, ok);
					flg[k] = 0;
				end
			end
			@(negedge ref_clk_in);
			{rxe, fce, pol, pg, rf, tst} = 6'($urandom);
			iev = 8'($urandom);
			flg[0] |= rxe;
			flg[1] |= fce;
			flg[2] |= pol;
			flg[3] |= pg;
			flg[4] |= ((|(iev & ien)) && glb) || tst;
			flg[5] |= rf;
			@(negedge ref_clk_in);
			{rxe, fce, pol, pg, rf, tst, iev} = '0;
			mgmt_host_model_i.acc(1, STATUS_SUMMARY_ADDR, 16'($urandom), got, ok);
			chk({15'h0, ok}, 16'h0);
			mgmt_host_model_i.acc(0, 5'h1f, 16'h0, got, ok);
			chk({ok, got[14:0]}, 16'h0);
			mgmt_host_model_i.acc(0, STATUS_SUMMARY_ADDR, 16'h0, got, ok);
			chk(got, model());
			chk({15'h0, sdq}, {15'h0, q});
			sdlow = !q;
			lklow = !lk;
		end
		// Mid-run reset must drop every latched flag
		@(negedge ref_clk_in);
		{xen, xf, xalg, sdr, lk, ql, jb, ane, anc, lb, fd, s10, lv} = '0;
		{rxe, fce, pol, pg, rf, tst} = 6'h3f;
		iev = 8'hff;
		flg = '{default: 1};
		q = 1'b0;
		sdlow = 1;
		lklow = 1;
		@(negedge ref_clk_in);
		{rxe, fce, pol, pg, rf, tst, iev} = '0;
		mgmt_host_model_i.acc(0, STATUS_SUMMARY_ADDR, 16'h0, got, ok);
		chk(got, model());
		rst_b_in = 0;
		repeat (2) @(negedge ref_clk_in);
		rst_b_in = 1;
		flg = '{default: 0};
		mgmt_host_model_i.acc(0, STATUS_SUMMARY_ADDR, 16'h0, got, ok);
		chk(got, 16'h0000);
		chk({15'h0, ok}, 16'h0001);
		end_of_test();
	end
endmodule
